// ===== tile_defs.vh
// Purpose: constants shared by the tile status and control register bank
// Assumes: included by bare name from each design file
// Notes:   register numbers are processor-status numbers, not byte addresses
`ifndef TILE_DEFS_VH
`define TILE_DEFS_VH

// ---------------------------------------------------------------
// register numbers
// ---------------------------------------------------------------
`define REG_VECTOR_BASE 8'h01
`define REG_FEATURE_CTRL 8'h02
`define REG_BOOT_STATUS 8'h03
`define REG_SECURITY 8'h05
`define REG_OSC_CTRL 8'h06
`define REG_CELL_COUNT 8'h07
`define REG_WIRE_COUNT 8'h08

// ---------------------------------------------------------------
// vector base layout
// ---------------------------------------------------------------
`define VEC_FIELD_HI 31
`define VEC_FIELD_LO 19
`define VEC_FIELD_W 13
`define VEC_PAD_W 3
`define VEC_RESET 13'h0000

// ---------------------------------------------------------------
// feature control bit positions
// ---------------------------------------------------------------
`define FC_RAM_SHUTDOWN 10
`define FC_AUTOSLEEP 9
`define FC_DIV_DYNAMIC 5
`define FC_DIV_ENABLE 4
`define FC_USB 1
`define FC_EXTMEM 0
`define FC_WRITE_MASK 32'h0000_0633

// ---------------------------------------------------------------
// boot status bit positions
// ---------------------------------------------------------------
`define BS_PROC_HI 23
`define BS_PROC_LO 16
`define BS_OVERRIDE 8
`define BS_SKIP_POLL 4
`define BS_FROM_RAM 3
`define BS_FROM_JTAG 2
`define BS_PLL_HI 1
`define BS_PLL_LO 0

// ---------------------------------------------------------------
// security bit positions
// ---------------------------------------------------------------
`define SEC_WRITE_LOCK 31
`define SEC_GLOBAL_DEBUG 14
`define SEC_FUSE_READ 9
`define SEC_FUSE_PROG 8
`define SEC_FUSE_MERGE 7
`define SEC_BOOT_OVERRIDE 5
`define SEC_JTAG_PLL 4
`define SEC_DEBUG_TAP 0
`define SEC_WRITE_MASK 32'h8000_43B1

// ---------------------------------------------------------------
// oscillator control and counters
// ---------------------------------------------------------------
`define OSC_CORE_ON 1
`define OSC_PERIPH_ON 0
`define OSC_COUNT_W 16
`define OSC_NUM 4

// ---------------------------------------------------------------
// clock divider ratio, in core clock cycles per enable pulse
// ---------------------------------------------------------------
`define CLK_DIV_RATIO 4'h8

`endif

// ===== ring_counter.v
// Purpose: counter of one ring oscillator's edges, clocked by clk, with a stable copy
// Assumes: osc_edge is one pulse per oscillator cycle, sampled on clk
// Notes:   the count itself is never reset, only the enable path is
`timescale 1ns/100ps
`include "tile_defs.vh"
module ring_counter (
  input wire clk,
  input wire reset,
  input wire enable,
  input wire osc_edge,
  output reg [`OSC_COUNT_W-1:0] count_r,
  output reg [`OSC_COUNT_W-1:0] held_r
);
  reg sync1_r;
  reg run_r;

  // power-up value of the count; system reset never touches it, so
  // without this the count would stay unknown for good
  initial begin
    count_r = 16'h0000;
  end

  // ---------------------------------------------------------------
  // two-stage enable pipeline, both stages on clk
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      sync1_r <= 1'b0;
      run_r <= 1'b0;
    end else begin
      sync1_r <= enable;
      run_r <= sync1_r;
    end
  end

  // ---------------------------------------------------------------
  // free-running count, kept through reset
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (run_r && osc_edge) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // held copy only moves while stopped, so a read never sees a moving
  // count; software still waits out the enable pipeline
  always @(posedge clk) begin
    if (!run_r) begin
      held_r <= count_r;
    end
  end
endmodule

// ===== vector_former.v
// Purpose: builds the event or interrupt destination address
// Assumes: event_taken is a one-cycle pulse with its vector beside it
// Notes:   result is registered, valid one cycle after the event
`timescale 1ns/100ps
`include "tile_defs.vh"
module vector_former (
  input wire clk,
  input wire reset,
  input wire event_taken,
  input wire [15:0] event_vector,
  input wire [`VEC_FIELD_W-1:0] base_field,
  output reg [31:0] target_addr_r,
  output reg target_valid_r
);
  always @(posedge clk) begin
    if (reset) begin
      target_addr_r <= 32'h0000_0000;
      target_valid_r <= 1'b0;
    end else begin
      target_valid_r <= event_taken;
      if (event_taken) begin
        // reserved base bits 18:16 read as zero
        target_addr_r <= {base_field, 3'h0, event_vector};
      end
    end
  end
endmodule

// ===== tile_status_control_bank.v
// Purpose: processor-status register bank of one processor tile
// Assumes: ps_* strobes come from the tile's status read/write path
// Notes:   one clock; oscillator edges arrive as sampled pulses
//
// Notes on behaviour
// - event address: upper 16 bits from vector base, lower from vector
// - vector base writable in bits 31:19, bits 18:0 read zero
// - feature bit 10 powers down tile RAMs; contents lost
// - feature bit 9 enables memory auto-sleep
// - feature bit 4 enables the core clock divider
// - feature bit 5 dynamic mode: divide only while all threads paused
// - bit 1 USB support, bit 0 external memory; other bits reserved
// - boot status read-only, processor number in bits 23:16
// - boot status: RAM, JTAG, poll skip, PLL strap pins; override from security bit 5
// - security register loaded from the fuse memory word
// - security bit 31 set locks out further security writes
// - security bit 14 blocks global debug, bit 0 the debug TAP
// - bit 9 blocks fuse reads, bit 8 the fuse programming port
// - security bit 7 merges fuse memory into one read space
// - security bit 5 forces boot from fuse memory
// - security bit 4 blocks JTAG access to PLL and boot registers
// - four ring oscillators with counters, started and stopped by software
// - oscillator control bit 1 core, bit 0 peripheral, reset zero
// - counts read in bits 15:0, upper zero, kept through reset
// - first count register is cell oscillator, second wire oscillator
// - oscillators run asynchronously and supply random bits
`timescale 1ns/100ps
`include "tile_defs.vh"
module tile_status_control_bank (
  input wire clk,
  input wire reset,
  // processor-status access
  input wire ps_write,
  input wire ps_read,
  input wire [7:0] ps_number,
  input wire [31:0] ps_wdata,
  output reg [31:0] ps_rdata,
  output reg ps_rvalid,
  // event address forming
  input wire event_taken,
  input wire [15:0] event_vector,
  output wire [31:0] event_target,
  output wire event_target_valid,
  // fuse memory security word
  input wire fuse_load,
  input wire [31:0] fuse_word,
  // boot straps, caught once after reset
  input wire [7:0] processor_number,
  input wire strap_boot_ram,
  input wire strap_boot_jtag,
  input wire strap_skip_poll,
  input wire [1:0] pll_strap_value,
  // thread activity for the dynamic divider
  input wire all_threads_paused,
  // ring oscillator edge pulses: cell, wire, periph cell, periph wire
  input wire [`OSC_NUM-1:0] osc_edge,
  // feature controls
  output reg ram_shutdown,
  output reg memory_autosleep_on,
  output reg usb_on,
  output reg external_memory_on,
  output reg divider_active,
  output reg core_clk_ce,
  // security controls
  output reg global_debug_block,
  output reg debug_tap_block,
  output reg fuse_read_block,
  output reg fuse_prog_block,
  output reg fuse_merge_space,
  output reg fuse_boot_override,
  output reg jtag_pll_block,
  // random bits from the oscillator counters
  output reg [`OSC_NUM-1:0] random_bits
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg [`VEC_FIELD_W-1:0] vector_base_r;
  reg [31:0] feature_r;
  reg [31:0] security_r;
  reg [1:0] osc_ctrl_r;
  reg [7:0] proc_num_r;
  reg [3:0] boot_flags_r;
  reg [1:0] pll_strap_r;
  reg straps_taken_r;
  reg [3:0] div_count_r;
  reg [3:0] div_count_nxt;
  reg ce_nxt;
  reg div_on_nxt;
  reg [31:0] rdata_nxt;
  wire [`OSC_COUNT_W-1:0] held0;
  wire [`OSC_COUNT_W-1:0] held1;
  wire [`OSC_COUNT_W-1:0] live0;
  wire [`OSC_COUNT_W-1:0] live1;
  wire [`OSC_COUNT_W-1:0] live2;
  wire [`OSC_COUNT_W-1:0] live3;
  wire wr_vec;
  wire wr_feat;
  wire wr_sec;
  wire wr_osc;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function [31:0] count_word;
    input [`OSC_COUNT_W-1:0] c;
    begin
      count_word = {16'h0000, c};
    end
  endfunction

  function hit;
    input [7:0] number;
    input [7:0] target;
    begin
      hit = (number == target);
    end
  endfunction

  assign wr_vec = ps_write && hit(ps_number, `REG_VECTOR_BASE);
  assign wr_feat = ps_write && hit(ps_number, `REG_FEATURE_CTRL);
  assign wr_sec = ps_write && hit(ps_number, `REG_SECURITY);
  assign wr_osc = ps_write && hit(ps_number, `REG_OSC_CTRL);

  // ---------------------------------------------------------------
  // writable registers
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      vector_base_r <= `VEC_RESET;
      feature_r <= 32'h0000_0000;
      osc_ctrl_r <= 2'h0;
    end else begin
      if (wr_vec) begin
        vector_base_r <= ps_wdata[`VEC_FIELD_HI:`VEC_FIELD_LO];
      end
      if (wr_feat) begin
        // reserved bits never stored
        feature_r <= ps_wdata & `FC_WRITE_MASK;
      end
      if (wr_osc) begin
        osc_ctrl_r <= ps_wdata[1:0];
      end
    end
  end

  // fuse load comes from hardware and wins over a software write in
  // the same cycle; the lock bit only gates software writes
  always @(posedge clk) begin
    if (reset) begin
      security_r <= 32'h0000_0000;
    end else if (fuse_load) begin
      security_r <= fuse_word & `SEC_WRITE_MASK;
    end else if (wr_sec && !security_r[`SEC_WRITE_LOCK]) begin
      security_r <= ps_wdata & `SEC_WRITE_MASK;
    end
  end

  // ---------------------------------------------------------------
  // boot straps, taken on the first edge after reset release
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      straps_taken_r <= 1'b0;
      proc_num_r <= 8'h00;
      boot_flags_r <= 4'h0;
      pll_strap_r <= 2'h0;
    end else if (!straps_taken_r) begin
      straps_taken_r <= 1'b1;
      proc_num_r <= processor_number;
      boot_flags_r <= {1'b0, strap_skip_poll, strap_boot_ram,
                       strap_boot_jtag};
      pll_strap_r <= pll_strap_value;
    end
  end

  // ---------------------------------------------------------------
  // read path: answer one cycle after the read strobe
  // ---------------------------------------------------------------
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (ps_number)
      `REG_VECTOR_BASE: begin
        rdata_nxt = {vector_base_r, 19'h00000};
      end
      `REG_FEATURE_CTRL: begin
        rdata_nxt = feature_r;
      end
      `REG_BOOT_STATUS: begin
        rdata_nxt[`BS_PROC_HI:`BS_PROC_LO] = proc_num_r;
        rdata_nxt[`BS_OVERRIDE] = security_r[`SEC_BOOT_OVERRIDE];
        rdata_nxt[`BS_SKIP_POLL] = boot_flags_r[2];
        rdata_nxt[`BS_FROM_RAM] = boot_flags_r[1];
        rdata_nxt[`BS_FROM_JTAG] = boot_flags_r[0];
        rdata_nxt[`BS_PLL_HI:`BS_PLL_LO] = pll_strap_r;
      end
      `REG_SECURITY: begin
        rdata_nxt = security_r;
      end
      `REG_OSC_CTRL: begin
        rdata_nxt = {30'h0000_0000, osc_ctrl_r};
      end
      `REG_CELL_COUNT: begin
        rdata_nxt = count_word(held0);
      end
      `REG_WIRE_COUNT: begin
        rdata_nxt = count_word(held1);
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      ps_rdata <= 32'h0000_0000;
      ps_rvalid <= 1'b0;
    end else begin
      ps_rvalid <= ps_read;
      if (ps_read) begin
        ps_rdata <= rdata_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // clock divider: the core clock itself is not gated here, the
  // divided rate leaves as a one-cycle enable pulse
  // ---------------------------------------------------------------
  always @* begin
    div_on_nxt = feature_r[`FC_DIV_ENABLE] &&
                 (!feature_r[`FC_DIV_DYNAMIC] ||
                  all_threads_paused);
    div_count_nxt = 4'h0;
    ce_nxt = 1'b1;
    if (div_on_nxt) begin
      if (div_count_r >= `CLK_DIV_RATIO - 4'h1) begin
        div_count_nxt = 4'h0;
        ce_nxt = 1'b1;
      end else begin
        div_count_nxt = div_count_r + 4'h1;
        ce_nxt = 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      div_count_r <= 4'h0;
      core_clk_ce <= 1'b1;
      divider_active <= 1'b0;
    end else begin
      div_count_r <= div_count_nxt;
      core_clk_ce <= ce_nxt;
      divider_active <= div_on_nxt;
    end
  end

  // ---------------------------------------------------------------
  // registered control outputs
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      ram_shutdown <= 1'b0;
      memory_autosleep_on <= 1'b0;
      usb_on <= 1'b0;
      external_memory_on <= 1'b0;
      global_debug_block <= 1'b0;
      debug_tap_block <= 1'b0;
      fuse_read_block <= 1'b0;
      fuse_prog_block <= 1'b0;
      fuse_merge_space <= 1'b0;
      fuse_boot_override <= 1'b0;
      jtag_pll_block <= 1'b0;
      random_bits <= 4'h0;
    end else begin
      // RAM contents are not kept; software must save them first
      ram_shutdown <= feature_r[`FC_RAM_SHUTDOWN];
      memory_autosleep_on <= feature_r[`FC_AUTOSLEEP];
      usb_on <= feature_r[`FC_USB];
      external_memory_on <= feature_r[`FC_EXTMEM];
      global_debug_block <= security_r[`SEC_GLOBAL_DEBUG];
      debug_tap_block <= security_r[`SEC_DEBUG_TAP];
      fuse_read_block <= security_r[`SEC_FUSE_READ];
      fuse_prog_block <= security_r[`SEC_FUSE_PROG];
      fuse_merge_space <= security_r[`SEC_FUSE_MERGE];
      fuse_boot_override <= security_r[`SEC_BOOT_OVERRIDE];
      jtag_pll_block <= security_r[`SEC_JTAG_PLL];
      random_bits <= {live3[0], live2[0], live1[0], live0[0]};
    end
  end

  // ---------------------------------------------------------------
  // ring oscillator counters: cell and wire on the core enable,
  // the peripheral pair on the peripheral enable
  // ---------------------------------------------------------------
  ring_counter cell_count (
    .clk(clk),
    .reset(reset),
    .enable(osc_ctrl_r[`OSC_CORE_ON]),
    .osc_edge(osc_edge[0]),
    .count_r(live0),
    .held_r(held0)
  );

  ring_counter wire_count (
    .clk(clk),
    .reset(reset),
    .enable(osc_ctrl_r[`OSC_CORE_ON]),
    .osc_edge(osc_edge[1]),
    .count_r(live1),
    .held_r(held1)
  );

  ring_counter periph_cell_count (
    .clk(clk),
    .reset(reset),
    .enable(osc_ctrl_r[`OSC_PERIPH_ON]),
    .osc_edge(osc_edge[2]),
    .count_r(live2),
    .held_r()
  );

  ring_counter periph_wire_count (
    .clk(clk),
    .reset(reset),
    .enable(osc_ctrl_r[`OSC_PERIPH_ON]),
    .osc_edge(osc_edge[3]),
    .count_r(live3),
    .held_r()
  );

  // ---------------------------------------------------------------
  // event destination address
  // ---------------------------------------------------------------
  vector_former vec_form (
    .clk(clk),
    .reset(reset),
    .event_taken(event_taken),
    .event_vector(event_vector),
    .base_field(vector_base_r),
    .target_addr_r(event_target),
    .target_valid_r(event_target_valid)
  );
endmodule

// ===== tile_status_control_bank_checker.sv
// Purpose: concurrent checks on the tile status and control bank ports
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the design from the testbench top file
`timescale 1ns/100ps
`include "tile_defs.vh"
module tile_status_control_bank_checker (
  input wire clk,
  input wire reset,
  input wire ps_write,
  input wire ps_read,
  input wire [7:0] ps_number,
  input wire [31:0] ps_wdata,
  input wire [31:0] ps_rdata,
  input wire ps_rvalid,
  input wire event_taken,
  input wire [15:0] event_vector,
  input wire [31:0] event_target,
  input wire event_target_valid,
  input wire fuse_load,
  input wire [31:0] fuse_word,
  input wire ram_shutdown,
  input wire memory_autosleep_on,
  input wire usb_on,
  input wire external_memory_on,
  input wire divider_active,
  input wire core_clk_ce,
  input wire global_debug_block,
  input wire debug_tap_block,
  input wire fuse_read_block,
  input wire fuse_prog_block,
  input wire fuse_merge_space,
  input wire fuse_boot_override,
  input wire jtag_pll_block
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [4:0] gap_r;
  logic [31:0] wd1_r, wd2_r, fw1_r, fw2_r;
  // two-cycle copies, since outputs lag their cause by two edges
  always @(posedge clk) begin
    wd1_r <= ps_wdata;
    wd2_r <= wd1_r;
    fw1_r <= fuse_word;
    fw2_r <= fw1_r;
    if (reset || !divider_active || core_clk_ce) gap_r <= 5'h00;
    else gap_r <= gap_r + 5'h01;
  end
  chk_event_addr: assert property (
    event_taken |=> event_target_valid
      && event_target[15:0] == $past(event_vector)
      && event_target[18:16] == 3'h0)
    else $error("event target address wrong");
  chk_event_idle: assert property (
    !event_taken |=> !event_target_valid)
    else $error("event target valid without event");
  chk_vector_reserved: assert property (
    ps_read && ps_number == `REG_VECTOR_BASE
      |=> ps_rvalid && ps_rdata[18:0] == 19'h0)
    else $error("vector base reserved bits set");
  chk_feature_reserved: assert property (
    ps_read && ps_number == `REG_FEATURE_CTRL
      |=> ps_rvalid && (ps_rdata & 32'hFFFF_F9CC) == 32'h0)
    else $error("feature reserved bits set");
  chk_boot_reserved: assert property (
    ps_read && ps_number == `REG_BOOT_STATUS |=> ps_rvalid
      && ps_rdata[31:24] == 8'h00 && ps_rdata[15:9] == 7'h00
      && ps_rdata[7:5] == 3'h0)
    else $error("boot status reserved bits set");
  chk_count_reserved: assert property (
    ps_read && (ps_number == `REG_CELL_COUNT
      || ps_number == `REG_WIRE_COUNT)
      |=> ps_rvalid && ps_rdata[31:16] == 16'h0000)
    else $error("count upper bits set");
  chk_feature_outputs: assert property (
    ps_write && ps_number == `REG_FEATURE_CTRL |-> ##2
      {ram_shutdown, memory_autosleep_on, usb_on, external_memory_on}
      == {wd2_r[10], wd2_r[9], wd2_r[1], wd2_r[0]})
    else $error("feature outputs do not follow write");
  chk_fuse_debug: assert property (
    fuse_load |-> ##2 global_debug_block == fw2_r[14]
      && debug_tap_block == fw2_r[0])
    else $error("debug blocks do not follow fuse word");
  chk_fuse_bits: assert property (
    fuse_load |-> ##2 {fuse_read_block, fuse_prog_block,
      fuse_merge_space, fuse_boot_override, jtag_pll_block}
      == {fw2_r[9], fw2_r[8], fw2_r[7], fw2_r[5], fw2_r[4]})
    else $error("fuse blocks do not follow fuse word");
  chk_divider_idle: assert property (
    !divider_active && $past(divider_active) == 1'b0 |-> core_clk_ce)
    else $error("clock enable low while not dividing");
  chk_divider_pulse: assert property (
    divider_active && core_clk_ce |=> !core_clk_ce || !divider_active)
    else $error("divided clock enable wider than one cycle");
  chk_divider_rate: assert property (
    divider_active |-> gap_r <= 5'h07)
    else $error("divided clock enable missing");
endmodule

// ===== test_tile_status_control_bank.sv
// Purpose: self-checking bench for the tile status and control bank
// Assumes: 200 MHz clock, synchronous active-high reset
// Notes:   oscillator edges are driven as one-cycle pulses
`timescale 1ns/100ps
`include "tile_defs.vh"
module test_tile_status_control_bank;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ps_write = 1'b0, ps_read = 1'b0, event_taken = 1'b0;
  logic fuse_load = 1'b0, all_threads_paused = 1'b0;
  logic [7:0] ps_number = 8'h00;
  logic [31:0] ps_wdata = 32'h0, fuse_word = 32'h0;
  logic [15:0] event_vector = 16'h0;
  logic [3:0] osc_edge = 4'h0;
  logic [31:0] ps_rdata, event_target, rd_data, c0, w0;
  logic ps_rvalid, event_target_valid, ram_shutdown, memory_autosleep_on;
  logic usb_on, external_memory_on, divider_active, core_clk_ce;
  logic global_debug_block, debug_tap_block, fuse_read_block;
  logic fuse_prog_block, fuse_merge_space, fuse_boot_override;
  logic jtag_pll_block, bit_before;
  logic [3:0] random_bits;
  int errors = 0;
  int tests_run = 0;
  int ce_count;
  // number, write data, expected read back
  logic [71:0] rows [0:9] = '{
    {8'h01, 32'hFFFF_FFFF, 32'hFFF8_0000},
    {8'h02, 32'hFFFF_FFFF, 32'h0000_0633},
    {8'h03, 32'hFFFF_FFFF, 32'h005A_001A},
    {8'h04, 32'hFFFF_FFFF, 32'h0000_0000},
    {8'h00, 32'hFFFF_FFFF, 32'h0000_0000},
    {8'h06, 32'hFFFF_FFFF, 32'h0000_0003},
    {8'h06, 32'h0000_0000, 32'h0000_0000},
    {8'h05, 32'h7FFF_FFFF, 32'h0000_43B1},
    {8'h03, 32'h0000_0000, 32'h005A_011A},
    {8'h02, 32'h0000_0000, 32'h0000_0000}};

  always #2.5 clk = ~clk;

  tile_status_control_bank i_tile_status_control_bank (
    .clk(clk), .reset(reset), .ps_write(ps_write), .ps_read(ps_read),
    .ps_number(ps_number), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata),
    .ps_rvalid(ps_rvalid), .event_taken(event_taken),
    .event_vector(event_vector), .event_target(event_target),
    .event_target_valid(event_target_valid), .fuse_load(fuse_load),
    .fuse_word(fuse_word), .processor_number(8'h5A),
    .strap_boot_ram(1'b1), .strap_boot_jtag(1'b0),
    .strap_skip_poll(1'b1), .pll_strap_value(2'h2),
    .all_threads_paused(all_threads_paused), .osc_edge(osc_edge),
    .ram_shutdown(ram_shutdown), .memory_autosleep_on(memory_autosleep_on),
    .usb_on(usb_on), .external_memory_on(external_memory_on),
    .divider_active(divider_active), .core_clk_ce(core_clk_ce),
    .global_debug_block(global_debug_block),
    .debug_tap_block(debug_tap_block), .fuse_read_block(fuse_read_block),
    .fuse_prog_block(fuse_prog_block), .fuse_merge_space(fuse_merge_space),
    .fuse_boot_override(fuse_boot_override),
    .jtag_pll_block(jtag_pll_block), .random_bits(random_bits));

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] num, input logic [31:0] data);
    @(posedge clk);
    ps_write <= 1'b1;
    ps_number <= num;
    ps_wdata <= data;
    @(posedge clk);
    ps_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] num, output logic [31:0] data);
    @(posedge clk);
    ps_read <= 1'b1;
    ps_number <= num;
    @(posedge clk);
    ps_read <= 1'b0;
    #1;
    check({31'h0, ps_rvalid}, 32'h1, "read answer");
    data = ps_rdata;
  endtask

  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge clk);
      osc_edge[idx] <= 1'b1;
      @(posedge clk);
      osc_edge[idx] <= 1'b0;
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // whole run is well under a thousand cycles
  initial begin
    #20000;
    errors++;
    print_verdict;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      wr(rows[i][71:64], rows[i][63:32]);
      rd(rows[i][71:64], rd_data);
      check(rd_data, rows[i][31:0], "readback");
    end
    wr(8'h02, 32'h0000_0030);
    tick(3);
    check({31'h0, divider_active}, 32'h0, "dynamic not paused");
    @(posedge clk);
    all_threads_paused <= 1'b1;
    tick(3);
    check({31'h0, divider_active}, 32'h1, "dynamic paused");
    ce_count = 0;
    repeat (16) begin
      tick(1);
      if (core_clk_ce === 1'b1) ce_count++;
    end
    check(ce_count, 32'h2, "divided enables");
    @(posedge clk);
    all_threads_paused <= 1'b0;
    wr(8'h02, 32'h0000_0010);
    tick(3);
    check({31'h0, divider_active}, 32'h1, "static divider");
    wr(8'h02, 32'h0000_0000);
    @(posedge clk);
    event_taken <= 1'b1;
    event_vector <= 16'hBEEF;
    @(posedge clk);
    event_vector <= 16'h1234;
    #1 check(event_target, 32'hFFF8_BEEF, "first event");
    @(posedge clk);
    event_taken <= 1'b0;
    #1 check(event_target, 32'hFFF8_1234, "second event");
    wr(8'h05, 32'h8000_4001);
    wr(8'h05, 32'h0000_0000);
    rd(8'h05, rd_data);
    check(rd_data, 32'h8000_4001, "locked security");
    @(posedge clk);
    fuse_load <= 1'b1;
    fuse_word <= 32'h0000_0211;
    @(posedge clk);
    fuse_load <= 1'b0;
    rd(8'h05, rd_data);
    check(rd_data, 32'h0000_0211, "fuse word");
    rd(8'h07, c0);
    rd(8'h08, w0);
    check(c0, 32'h0, "cell count at power up");
    check(w0, 32'h0, "wire count at power up");
    wr(8'h06, 32'h0000_0002);
    tick(3);
    pulse(0, 5);
    pulse(1, 3);
    rd(8'h07, rd_data);
    check(rd_data, c0, "frozen while running");
    wr(8'h06, 32'h0000_0000);
    tick(12);
    pulse(0, 2);
    rd(8'h07, rd_data);
    check(rd_data, {16'h0, c0[15:0] + 16'h5}, "cell count");
    rd(8'h08, rd_data);
    check(rd_data, {16'h0, w0[15:0] + 16'h3}, "wire count");
    check({30'h0, random_bits[1:0]}, {30'h0, ~w0[0], ~c0[0]}, "lsbs");
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(8'h07, rd_data);
    check(rd_data, {16'h0, c0[15:0] + 16'h5}, "count kept");
    foreach (rows[i]) begin
      if (rows[i][71:64] inside {8'h01, 8'h02, 8'h06}) begin
        rd(rows[i][71:64], rd_data);
        check(rd_data, 32'h0, "reset value");
      end
    end
    wr(8'h06, 32'h0000_0001);
    tick(3);
    bit_before = random_bits[2];
    pulse(2, 3);
    tick(3);
    check({31'h0, random_bits[2]}, {31'h0, ~bit_before}, "periph");
    wr(8'h06, 32'h0000_0000);
    print_verdict;
  end
endmodule

bind tile_status_control_bank tile_status_control_bank_checker
  i_tile_status_control_bank_checker (
  .clk, .reset, .ps_write, .ps_read, .ps_number, .ps_wdata, .ps_rdata,
  .ps_rvalid, .event_taken, .event_vector, .event_target,
  .event_target_valid, .fuse_load, .fuse_word, .ram_shutdown,
  .memory_autosleep_on, .usb_on, .external_memory_on, .divider_active,
  .core_clk_ce, .global_debug_block, .debug_tap_block, .fuse_read_block,
  .fuse_prog_block, .fuse_merge_space, .fuse_boot_override,
  .jtag_pll_block);
